// file: rtl/triple_reload_timer_unit.sv
`timescale 1ns/100ps
module triple_reload_timer_unit (
   // clock and reset
   input  wire logic                             CLK,
   input  wire logic                             RST_B,
   // AHB-Lite slave
   input  wire logic                             HSEL,
   input  wire logic [7:0]                       HADDR,
   input  wire logic [1:0]                       HTRANS,
   input  wire logic                             HWRITE,
   input  wire logic [2:0]                       HSIZE,
   input  wire logic [31:0]                      HWDATA,
   input  wire logic                             HREADY,
   output logic                                  HREADYOUT,
   output logic      [31:0]                      HRDATA,
   output logic                                  HRESP,
   // selected count sources, one-cycle pulses
   input  wire logic                             FIRST_SRC_TICK,
   input  wire logic                             WIDE_SRC_TICK,
   input  wire logic                             THIRD_SRC_TICK,
   // counter pins
   input  wire logic                             WIDE_TIMER_INPUT_PIN,
   input  wire logic                             THIRD_TIMER_IO_PIN_IN,
   output logic                                  THIRD_TIMER_IO_PIN_OUT,
   output logic                                  THIRD_TIMER_IO_PIN_OE,
   output logic                                  INVERTED_PULSE_PIN,
   // interrupt requests and acceptance
   input  wire logic [timer_unit_pkg::IRQ_N-1:0] IRQ_ACK,
   output logic      [timer_unit_pkg::IRQ_N-1:0] IRQ_REQ
);

   typedef struct packed {
      logic                             dp_write;
      logic                             dp_read;
      logic [7:0]                       dp_addr;
      logic                             hready;
      logic [31:0]                      hrdata;
      timer_unit_pkg::wide_mode_t       wide_mode;
      logic                             wide_edge;
      logic                             wide_stop;
      logic [7:0]                       low_wbuf;
      logic [7:0]                       low_rbuf;
      logic [15:0]                      capt;
      logic                             capt_hold;
      timer_unit_pkg::third_mode_t      third_mode;
      logic                             third_edge;
      logic                             third_stop;
      logic                             third_wctl;
      logic                             inv_valid;
      logic                             pulse;
      logic                             pin_oe;
      logic                             inv_out;
      logic [timer_unit_pkg::IRQ_N-1:0] irq;
   } unit_state_t;

   unit_state_t st_reg;
   unit_state_t st_next;

   // picks the active edge: 0 falling, 1 rising
   function automatic logic sel_edge(input logic edge_sel, input logic rise,
                                     input logic fall);
      sel_edge = edge_sel ? rise : fall;
   endfunction

   // true when a data-phase write targets the given offset
   function automatic logic wr_hit(input unit_state_t s, input logic [7:0] ofs);
      wr_hit = s.dp_write && (s.dp_addr == ofs);
   endfunction

   // synchronised pins
   logic wide_lvl;
   logic wide_rise;
   logic wide_fall;
   logic third_lvl;
   logic third_rise;
   logic third_fall;

   pin_sync u_wide_sync (
      .clk   (CLK),
      .rst_b (RST_B),
      .pin   (WIDE_TIMER_INPUT_PIN),
      .level (wide_lvl),
      .rise  (wide_rise),
      .fall  (wide_fall)
   );

   pin_sync u_third_sync (
      .clk   (CLK),
      .rst_b (RST_B),
      .pin   (THIRD_TIMER_IO_PIN_IN),
      .level (third_lvl),
      .rise  (third_rise),
      .fall  (third_fall)
   );

   // counter wiring
   logic [7:0]  first_pre_val;
   logic [7:0]  first_cnt_val;
   logic [15:0] wide_val;
   logic [7:0]  third_pre_val;
   logic [7:0]  third_cnt_val;
   logic        first_pre_uf;
   logic        first_cnt_uf;
   logic        wide_uf;
   logic        third_pre_uf;
   logic        third_cnt_uf;
   logic        wide_measure;
   logic        wide_act;
   logic        wide_tick;
   logic        third_act;
   logic        third_tick;
   logic        third_wr_count;
   logic [15:0] wide_wdata;

   // period and high/low width modes capture instead of showing the count
   assign wide_measure = (st_reg.wide_mode == timer_unit_pkg::WMODE_PERIOD) ||
                         (st_reg.wide_mode == timer_unit_pkg::WMODE_PULSE_HL);

   // high/low width mode takes both edges whatever the select bit says
   assign wide_act = (st_reg.wide_mode == timer_unit_pkg::WMODE_PULSE_HL) ?
                     (wide_rise | wide_fall) :
                     sel_edge(st_reg.wide_edge, wide_rise, wide_fall);

   // event mode counts pin edges, all other modes the selected source
   assign wide_tick = !st_reg.wide_stop &&
                      ((st_reg.wide_mode == timer_unit_pkg::WMODE_EVENT) ?
                       wide_act : WIDE_SRC_TICK);

   assign third_act = sel_edge(st_reg.third_edge, third_rise, third_fall);

   // third prescaler input depends on mode; stop halts every mode
   always_comb
   begin
      third_tick = 1'b0;
      unique case (st_reg.third_mode)
         timer_unit_pkg::TMODE_TIMER,
         timer_unit_pkg::TMODE_PULSE_OUT:
            third_tick = THIRD_SRC_TICK;
         timer_unit_pkg::TMODE_EVENT:
            third_tick = third_act;
         timer_unit_pkg::TMODE_WIDTH:
            third_tick = THIRD_SRC_TICK && (third_lvl == !st_reg.third_edge);
      endcase
      if (st_reg.third_stop)
         third_tick = 1'b0;
   end

   // write control 1 means latch only
   assign third_wr_count = !st_reg.third_wctl;
   assign wide_wdata     = {HWDATA[7:0], st_reg.low_wbuf};

   // first timer: prescaler then counter, free running
   reload_counter #(.W(8)) u_first_pre (
      .clk       (CLK),
      .rst_b     (RST_B),
      .tick      (FIRST_SRC_TICK),
      .wr_latch  (wr_hit(st_reg, timer_unit_pkg::OFS_FIRST_PRE)),
      .wr_count  (wr_hit(st_reg, timer_unit_pkg::OFS_FIRST_PRE)),
      .reload    (1'b0),
      .wdata     (HWDATA[7:0]),
      .rst_val   (timer_unit_pkg::RST_BYTE),
      .count_val (first_pre_val),
      .underflow (first_pre_uf)
   );

   reload_counter #(.W(8)) u_first_cnt (
      .clk       (CLK),
      .rst_b     (RST_B),
      .tick      (first_pre_uf),
      .wr_latch  (wr_hit(st_reg, timer_unit_pkg::OFS_FIRST_CNT)),
      .wr_count  (wr_hit(st_reg, timer_unit_pkg::OFS_FIRST_CNT)),
      .reload    (1'b0),
      .wdata     (HWDATA[7:0]),
      .rst_val   (timer_unit_pkg::RST_BYTE),
      .count_val (first_cnt_val),
      .underflow (first_cnt_uf)
   );

   // wide timer: one 16-bit counter, loaded only by the high-byte write
   reload_counter #(.W(16)) u_wide (
      .clk       (CLK),
      .rst_b     (RST_B),
      .tick      (wide_tick),
      .wr_latch  (wr_hit(st_reg, timer_unit_pkg::OFS_WIDE_HIGH)),
      .wr_count  (wr_hit(st_reg, timer_unit_pkg::OFS_WIDE_HIGH)),
      .reload    (wide_measure && wide_act),
      .wdata     (wide_wdata),
      .rst_val   (timer_unit_pkg::RST_WORD),
      .count_val (wide_val),
      .underflow (wide_uf)
   );

   // third timer: prescaler then counter, write control chooses the targets
   reload_counter #(.W(8)) u_third_pre (
      .clk       (CLK),
      .rst_b     (RST_B),
      .tick      (third_tick),
      .wr_latch  (wr_hit(st_reg, timer_unit_pkg::OFS_THIRD_PRE)),
      .wr_count  (wr_hit(st_reg, timer_unit_pkg::OFS_THIRD_PRE) && third_wr_count),
      .reload    (1'b0),
      .wdata     (HWDATA[7:0]),
      .rst_val   (timer_unit_pkg::RST_BYTE),
      .count_val (third_pre_val),
      .underflow (third_pre_uf)
   );

   reload_counter #(.W(8)) u_third_cnt (
      .clk       (CLK),
      .rst_b     (RST_B),
      .tick      (third_pre_uf),
      .wr_latch  (wr_hit(st_reg, timer_unit_pkg::OFS_THIRD_CNT)),
      .wr_count  (wr_hit(st_reg, timer_unit_pkg::OFS_THIRD_CNT) && third_wr_count),
      .reload    (1'b0),
      .wdata     (HWDATA[7:0]),
      .rst_val   (timer_unit_pkg::RST_BYTE),
      .count_val (third_cnt_val),
      .underflow (third_cnt_uf)
   );

   // bus, mode, capture, pulse and flag logic
   always_comb
   begin
      logic [15:0]                      wide_rd;
      logic                             rd_now;
      logic                             capt_free;
      logic [timer_unit_pkg::IRQ_N-1:0] irq_set;
      wide_rd   = '0;
      rd_now    = 1'b0;
      capt_free = 1'b0;
      irq_set   = '0;
      st_next   = st_reg;

      // address phase: writes go straight to data phase, reads wait a cycle
      st_next.dp_write = 1'b0;
      rd_now           = st_reg.dp_read && !st_reg.hready;
      if (rd_now)
      begin
         st_next.dp_read = 1'b0;
         st_next.hready  = 1'b1;
      end
      if (HSEL && HREADY && HTRANS[1])
      begin
         st_next.dp_addr  = HADDR;
         st_next.dp_write = HWRITE;
         st_next.dp_read  = !HWRITE;
         st_next.hready   = HWRITE;   // one wait state keeps read data registered
      end

      // reads sample state one edge after the address phase
      wide_rd = wide_measure ? st_reg.capt : wide_val;
      if (rd_now)
      begin
         st_next.hrdata = '0;   // unmapped offsets read zero
         unique case (st_reg.dp_addr)
            timer_unit_pkg::OFS_FIRST_PRE:  st_next.hrdata[7:0] = first_pre_val;
            timer_unit_pkg::OFS_FIRST_CNT:  st_next.hrdata[7:0] = first_cnt_val;
            timer_unit_pkg::OFS_WIDE_HIGH:
            begin
               st_next.hrdata[7:0] = wide_rd[15:8];
               st_next.low_rbuf    = wide_rd[7:0];
            end
            timer_unit_pkg::OFS_WIDE_LOW:   st_next.hrdata[7:0] = st_reg.low_rbuf;
            timer_unit_pkg::OFS_WIDE_MODE:
               st_next.hrdata[5:0] = {2'b00, st_reg.wide_stop, st_reg.wide_edge,
                                      st_reg.wide_mode};
            timer_unit_pkg::OFS_THIRD_PRE:  st_next.hrdata[7:0] = third_pre_val;
            timer_unit_pkg::OFS_THIRD_CNT:  st_next.hrdata[7:0] = third_cnt_val;
            timer_unit_pkg::OFS_THIRD_MODE:
               st_next.hrdata[5:0] = {st_reg.inv_valid, st_reg.third_wctl,
                                      st_reg.third_stop, st_reg.third_edge,
                                      st_reg.third_mode};
            timer_unit_pkg::OFS_IRQ_FLAGS:
               st_next.hrdata[timer_unit_pkg::IRQ_N-1:0] = st_reg.irq;
            default:                        st_next.hrdata = '0;
         endcase
      end

      // the low-byte read ends the pair and frees the held capture
      capt_free = !st_reg.capt_hold ||
                  (rd_now && (st_reg.dp_addr == timer_unit_pkg::OFS_WIDE_LOW));
      if (!capt_free)
         st_next.capt_hold = 1'b1;
      else
         st_next.capt_hold = 1'b0;
      if (wide_measure && wide_act && capt_free)
      begin
         st_next.capt      = wide_val;
         st_next.capt_hold = 1'b1;
      end

      // byte buffer for the wide write pair
      if (wr_hit(st_reg, timer_unit_pkg::OFS_WIDE_LOW))
         st_next.low_wbuf = HWDATA[7:0];

      // mode registers
      if (wr_hit(st_reg, timer_unit_pkg::OFS_WIDE_MODE))
      begin
         st_next.wide_mode = timer_unit_pkg::wide_mode_t'(HWDATA[1:0]);
         st_next.wide_edge = HWDATA[timer_unit_pkg::EDGE_BIT];
         st_next.wide_stop = HWDATA[timer_unit_pkg::STOP_BIT];
      end
      if (wr_hit(st_reg, timer_unit_pkg::OFS_THIRD_MODE))
      begin
         st_next.third_mode = timer_unit_pkg::third_mode_t'(HWDATA[1:0]);
         st_next.third_edge = HWDATA[timer_unit_pkg::EDGE_BIT];
         st_next.third_stop = HWDATA[timer_unit_pkg::STOP_BIT];
         st_next.third_wctl = HWDATA[timer_unit_pkg::WCTL_BIT];
         st_next.inv_valid  = HWDATA[timer_unit_pkg::INV_OUT_BIT];
         st_next.pulse      = !HWDATA[timer_unit_pkg::EDGE_BIT];
      end

      // pulse output toggles on each third counter underflow
      if ((st_reg.third_mode == timer_unit_pkg::TMODE_PULSE_OUT) && third_cnt_uf)
         st_next.pulse = !st_reg.pulse;
      st_next.pin_oe  = (st_next.third_mode == timer_unit_pkg::TMODE_PULSE_OUT);
      st_next.inv_out = st_next.inv_valid && !st_next.pulse;

      // request flag sources
      irq_set[timer_unit_pkg::IRQ_FIRST]     = first_cnt_uf;
      irq_set[timer_unit_pkg::IRQ_WIDE]      = wide_uf;
      irq_set[timer_unit_pkg::IRQ_WIDE_PIN]  = wide_act;
      irq_set[timer_unit_pkg::IRQ_THIRD]     = third_cnt_uf;
      irq_set[timer_unit_pkg::IRQ_THIRD_PIN] = third_act &&
         (st_reg.third_mode != timer_unit_pkg::TMODE_PULSE_OUT);

      // clears by zero write or acceptance, a new event wins over both
      st_next.irq = st_reg.irq & ~IRQ_ACK;
      if (wr_hit(st_reg, timer_unit_pkg::OFS_IRQ_FLAGS))
         st_next.irq = st_next.irq & HWDATA[timer_unit_pkg::IRQ_N-1:0];
      st_next.irq = st_next.irq | irq_set;
   end

   // bus, mode, capture, pulse and flag state in one register; counters and synchronisers keep their own
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         st_reg        <= '0;
         st_reg.hready <= 1'b1;
         st_reg.pulse  <= 1'b1;
      end
      else
         st_reg <= st_next;
   end

   // outputs straight from the state register, except HRESP tied low
   assign HREADYOUT              = st_reg.hready;
   assign HRDATA                 = st_reg.hrdata;
   assign HRESP                  = 1'b0;
   assign THIRD_TIMER_IO_PIN_OUT = st_reg.pulse;
   assign THIRD_TIMER_IO_PIN_OE  = st_reg.pin_oe;
   assign INVERTED_PULSE_PIN     = st_reg.inv_out;
   assign IRQ_REQ                = st_reg.irq;

endmodule

// file: rtl/timer_unit_pkg.sv
package timer_unit_pkg;

   // register byte offsets, one aligned word each
   localparam logic [7:0] OFS_FIRST_PRE   = 8'h00;
   localparam logic [7:0] OFS_FIRST_CNT   = 8'h04;
   localparam logic [7:0] OFS_WIDE_LOW    = 8'h08;
   localparam logic [7:0] OFS_WIDE_HIGH   = 8'h0c;
   localparam logic [7:0] OFS_WIDE_MODE   = 8'h10;
   localparam logic [7:0] OFS_THIRD_PRE   = 8'h14;
   localparam logic [7:0] OFS_THIRD_CNT   = 8'h18;
   localparam logic [7:0] OFS_THIRD_MODE  = 8'h1c;
   localparam logic [7:0] OFS_IRQ_FLAGS   = 8'h20;

   // mode register fields; mode, edge and stop in both mode registers, write control and inverted output in the third only
   localparam int MODE_LSB     = 0;
   localparam int EDGE_BIT     = 2;
   localparam int STOP_BIT     = 3;
   localparam int WCTL_BIT     = 4;
   localparam int INV_OUT_BIT  = 5;

   // interrupt request flag positions
   localparam int IRQ_FIRST    = 0;
   localparam int IRQ_WIDE     = 1;
   localparam int IRQ_WIDE_PIN = 2;
   localparam int IRQ_THIRD    = 3;
   localparam int IRQ_THIRD_PIN = 4;
   localparam int IRQ_N        = 5;

   // reset values of latches and counts
   localparam logic [7:0]  RST_BYTE = 8'hff;
   localparam logic [15:0] RST_WORD = 16'hffff;

   typedef enum logic [1:0] {
      WMODE_TIMER,
      WMODE_PERIOD,
      WMODE_EVENT,
      WMODE_PULSE_HL
   } wide_mode_t;

   typedef enum logic [1:0] {
      TMODE_TIMER,
      TMODE_PULSE_OUT,
      TMODE_EVENT,
      TMODE_WIDTH
   } third_mode_t;

endpackage

// file: rtl/reload_counter.sv
`timescale 1ns/100ps
module reload_counter #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_b,
   // control
   input  wire logic         tick,
   input  wire logic         wr_latch,
   input  wire logic         wr_count,
   input  wire logic         reload,
   input  wire logic [W-1:0] wdata,
   input  wire logic [W-1:0] rst_val,
   // status
   output logic      [W-1:0] count_val,
   output logic              underflow
);

   typedef struct packed {
      logic [W-1:0] latch;
      logic [W-1:0] cnt;
   } cnt_state_t;

   cnt_state_t st_reg;
   cnt_state_t st_next;

   // a software write to the count wins over counting in the same cycle
   assign underflow = tick && !wr_count && !reload && (st_reg.cnt == '0);
   assign count_val = st_reg.cnt;

   // next state: write, forced reload, then counting
   always_comb
   begin
      st_next = st_reg;
      if (wr_latch)
         st_next.latch = wdata;
      if (wr_count)
         st_next.cnt = wdata;
      else if (reload)
         st_next.cnt = st_reg.latch;
      else if (underflow)
         st_next.cnt = st_reg.latch;   // reload on the pulse after zero
      else if (tick)
         st_next.cnt = st_reg.cnt - 1'b1;
   end

   // reset loads all ones, a fixed constant; the rst_val input is not used
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         st_reg <= '1;
      else
         st_reg <= st_next;
   end

endmodule

// file: rtl/pin_sync.sv
`timescale 1ns/100ps
module pin_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // raw pin
   input  wire logic pin,
   // synchronised level and edges
   output logic      level,
   output logic      rise,
   output logic      fall
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } sync_state_t;

   sync_state_t st_reg;
   sync_state_t st_next;

   // s1 feeds s2 only; edges come from s2 against s3
   always_comb
   begin
      st_next    = st_reg;
      st_next.s1 = pin;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign level = st_reg.s2;
   assign rise  = st_reg.s2 & ~st_reg.s3;
   assign fall  = ~st_reg.s2 & st_reg.s3;

endmodule

// file: testbench/timer_unit_asserts.sv
`timescale 1ns/100ps
module timer_unit_asserts (
   // clock, reset and bus
   input wire logic       CLK,
   input wire logic       RST_B,
   input wire logic       HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic       HWRITE,
   input wire logic       HREADY,
   input wire logic       HREADYOUT,
   input wire logic       HRESP,
   // counting, pins and flags
   input wire logic       FIRST_SRC_TICK,
   input wire logic       WIDE_TIMER_INPUT_PIN,
   input wire logic       THIRD_TIMER_IO_PIN_IN,
   input wire logic       THIRD_TIMER_IO_PIN_OUT,
   input wire logic       INVERTED_PULSE_PIN,
   input wire logic [4:0] IRQ_ACK,
   input wire logic [4:0] IRQ_REQ
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // a transfer accepted at this edge
   wire take = HSEL && HREADY && HTRANS[1];
   resp_okay_a: assert property (!HRESP) else $error("resp not okay");
   write_nowait_a: assert property (take && HWRITE |=> HREADYOUT) else $error("write wait");
   read_wait_a: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
      else $error("read wait wrong");
   wait_once_a: assert property (!HREADYOUT |=> HREADYOUT) else $error("long wait");
   first_flag_a: assert property ($rose(IRQ_REQ[0]) |->
      $past(FIRST_SRC_TICK) || $past(FIRST_SRC_TICK, 2)) else $error("flag without tick");
   ack_clear_a: assert property (IRQ_ACK[0] && !FIRST_SRC_TICK &&
      !$past(FIRST_SRC_TICK) |=> !IRQ_REQ[0]) else $error("ack kept flag");
   inv_pin_a: assert property (INVERTED_PULSE_PIN |->
      !THIRD_TIMER_IO_PIN_OUT || !$past(THIRD_TIMER_IO_PIN_OUT)) else $error("inverse wrong");
   wide_quiet_a: assert property ($stable(WIDE_TIMER_INPUT_PIN) [*6]
      |=> !$rose(IRQ_REQ[2])) else $error("wide pin flag without edge");
   third_quiet_a: assert property ($stable(THIRD_TIMER_IO_PIN_IN) [*6]
      |=> !$rose(IRQ_REQ[4])) else $error("third pin flag without edge");
   read_seen_c: cover property (take && !HWRITE);
   first_uf_c: cover property ($rose(IRQ_REQ[0]));
   inv_rise_c: cover property ($rose(INVERTED_PULSE_PIN));
endmodule
bind triple_reload_timer_unit timer_unit_asserts timer_unit_asserts_i (
   .CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
   .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ_ACK(IRQ_ACK),
   .FIRST_SRC_TICK(FIRST_SRC_TICK), .WIDE_TIMER_INPUT_PIN(WIDE_TIMER_INPUT_PIN),
   .THIRD_TIMER_IO_PIN_IN(THIRD_TIMER_IO_PIN_IN), .IRQ_REQ(IRQ_REQ),
   .THIRD_TIMER_IO_PIN_OUT(THIRD_TIMER_IO_PIN_OUT), .INVERTED_PULSE_PIN(INVERTED_PULSE_PIN));

// file: testbench/pin_source_model.sv
`timescale 1ns/100ps
module pin_source_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // wanted level and answer delay
   input  wire logic       want,
   input  wire logic [3:0] dly,
   // driven pin
   output logic            pin
);
   logic [3:0] wait_reg;
   // a slow source shows the new level only after dly cycles
   always @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         pin <= 1'b0;
         wait_reg <= 4'h0;
      end
      else if (want == pin)
         wait_reg <= 4'h0;
      else if (wait_reg >= dly)
         pin <= want;
      else
         wait_reg <= wait_reg + 4'h1;
endmodule

// file: testbench/triple_reload_timer_unit_tb.sv
`timescale 1ns/100ps
module triple_reload_timer_unit_tb;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        hsel, hwrite, t1, tw, t3, want_w, want_t;
   logic [1:0]  htrans;
   logic [7:0]  haddr;
   logic [31:0] hwdata, rdat, seed = 32'd5422;
   logic [4:0]  ack;
   logic [3:0]  dly;
   logic [15:0] w16;
   wire  [31:0] hrdata;
   wire  [4:0]  irq;
   wire         hready, out3, oe3, inv, pw, pt;
   wire         pin3 = oe3 ? out3 : pt;
   int          n_errors = 0;
   int          num_checks = 0;
   int          n, m, e;
   always #50 clk = ~clk;
   triple_reload_timer_unit triple_reload_timer_unit_i (
      .CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready),
      .HRDATA(hrdata), .HRESP(), .FIRST_SRC_TICK(t1), .WIDE_SRC_TICK(tw), .THIRD_SRC_TICK(t3),
      .WIDE_TIMER_INPUT_PIN(pw), .THIRD_TIMER_IO_PIN_IN(pin3), .THIRD_TIMER_IO_PIN_OUT(out3),
      .THIRD_TIMER_IO_PIN_OE(oe3), .INVERTED_PULSE_PIN(inv), .IRQ_ACK(ack), .IRQ_REQ(irq));
   pin_source_model wide_src (.clk(clk), .rst_b(rst_b), .want(want_w), .dly(dly), .pin(pw));
   pin_source_model third_src (.clk(clk), .rst_b(rst_b), .want(want_t), .dly(dly), .pin(pt));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one single transfer; address held until ready, read data into rdat
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rdat = hrdata;
   endtask
   task automatic wrw(input logic [15:0] v);
      bus(1'b1, timer_unit_pkg::OFS_WIDE_LOW, 32'(v[7:0]));
      bus(1'b1, timer_unit_pkg::OFS_WIDE_HIGH, 32'(v[15:8]));
   endtask
   task automatic rdw();
      bus(1'b0, timer_unit_pkg::OFS_WIDE_HIGH, 32'h0);
      w16[15:8] = rdat[7:0];
      bus(1'b0, timer_unit_pkg::OFS_WIDE_LOW, 32'h0);
      w16[7:0] = rdat[7:0];
   endtask
   task automatic set3(input logic [7:0] p, input logic [7:0] c);
      bus(1'b1, timer_unit_pkg::OFS_THIRD_PRE, 32'(p));
      bus(1'b1, timer_unit_pkg::OFS_THIRD_CNT, 32'(c));
   endtask
   task automatic mode(input logic [7:0] a, input int v);
      bus(1'b1, a, 32'(v));
   endtask
   // one count pulse per cycle on the masked sources, then let flags land
   task automatic ticks(input int k, input logic [2:0] mask);
      repeat (k)
      begin
         {t1, tw, t3} <= mask;
         @(posedge clk);
      end
      {t1, tw, t3} <= 3'h0;
      repeat (2) @(posedge clk);
   endtask
   // pin levels change after a random source delay plus the sync stages
   task automatic pins(input logic a, input logic b);
      dly <= 4'(rnd() % 4);
      want_w <= a;
      want_t <= b;
      repeat (12) @(posedge clk);
   endtask
   task automatic chkirq(input logic [31:0] exp);
      @(posedge clk);
      chk(32'(irq), exp);
   endtask
   task automatic rd3(input logic [31:0] exp);
      bus(1'b0, timer_unit_pkg::OFS_THIRD_CNT, 32'h0);
      chk(rdat, exp);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      {hsel, hwrite, t1, tw, t3, want_w, want_t, htrans, haddr, hwdata, ack, dly} = '0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      bus(1'b0, 8'h24, 32'h0);
      chk(rdat, 32'h0);
      // first timer cascade with random reloads
      n = rnd() % 3 + 1;
      m = rnd() % 3 + 1;
      bus(1'b1, timer_unit_pkg::OFS_FIRST_PRE, 32'(n));
      bus(1'b1, timer_unit_pkg::OFS_FIRST_CNT, 32'(m));
      bus(1'b0, timer_unit_pkg::OFS_FIRST_PRE, 32'h0);
      chk(rdat, 32'(n));
      ticks((n + 1) * (m + 1) - 1, 3'h4);
      chkirq(32'h0);
      ticks(1, 3'h4);
      chkirq(32'h1);
      bus(1'b0, timer_unit_pkg::OFS_FIRST_CNT, 32'h0);
      chk(rdat, 32'(m));
      mode(timer_unit_pkg::OFS_IRQ_FLAGS, 0);
      mode(timer_unit_pkg::OFS_IRQ_FLAGS, 31);
      chkirq(32'h0);
      // wide timer: stop, then a period capture that holds while counting goes on
      wrw(16'h0100);
      ticks(5, 3'h2);
      rdw();
      chk(32'(w16), 32'h00fb);
      mode(timer_unit_pkg::OFS_WIDE_MODE, 8);
      ticks(3, 3'h2);
      rdw();
      chk(32'(w16), 32'h00fb);
      mode(timer_unit_pkg::OFS_WIDE_MODE, 5);
      pins(1'b1, 1'b0);
      chkirq(32'h4);
      ticks(3, 3'h2);
      rdw();
      chk(32'(w16), 32'h00fb);
      mode(timer_unit_pkg::OFS_WIDE_MODE, 0);
      rdw();
      chk(32'(w16), 32'h00fd);
      mode(timer_unit_pkg::OFS_WIDE_MODE, 7);
      mode(timer_unit_pkg::OFS_IRQ_FLAGS, 0);
      pins(1'b0, 1'b0);
      chkirq(32'h4);
      // event counting on both pins, each edge polarity
      for (e = 0; e < 2; e++)
      begin
         mode(timer_unit_pkg::OFS_WIDE_MODE, 2 + 4 * e);
         mode(timer_unit_pkg::OFS_THIRD_MODE, 2 + 4 * e);
         wrw(16'h0010);
         set3(8'h00, 8'h10);
         repeat (2)
         begin
            pins(1'b1, 1'b1);
            pins(1'b0, 1'b0);
         end
         rdw();
         chk(32'(w16), 32'h000e);
         rd3(32'h0e);
      end
      // pulse output from both start levels with the inverted copy on
      for (e = 0; e < 2; e++)
      begin
         mode(timer_unit_pkg::OFS_THIRD_MODE, 33 + 4 * e);
         set3(8'h01, 8'h01);
         mode(timer_unit_pkg::OFS_IRQ_FLAGS, 0);
         ticks(3, 3'h1);
         chk(32'({oe3, out3, inv, irq[3]}), 32'({1'b1, !e[0], e[0], 1'b0}));
         ticks(1, 3'h1);
         chk(32'({oe3, out3, inv, irq[3]}), 32'({1'b1, e[0], !e[0], 1'b1}));
      end
      // one more full first-timer period so the acceptance has a flag to clear
      ticks((n + 1) * (m + 1), 3'h4);
      chk(32'(irq[0]), 32'h1);
      ack <= 5'h09;
      @(posedge clk);
      ack <= 5'h00;
      chkirq(32'h0);
      // latch-only write reaches the count at the next reload
      mode(timer_unit_pkg::OFS_THIRD_MODE, 16);
      bus(1'b1, timer_unit_pkg::OFS_THIRD_CNT, 32'h05);
      rd3(32'h01);
      ticks(4, 3'h1);
      rd3(32'h05);
      // gated counting follows the pin level
      for (e = 0; e < 2; e++)
      begin
         pins(1'b0, e[0]);
         mode(timer_unit_pkg::OFS_THIRD_MODE, 3 + 4 * e);
         set3(8'h00, 8'h09);
         ticks(3, 3'h1);
         pins(1'b0, !e[0]);
         ticks(3, 3'h1);
         rd3(32'h06);
      end
      results();
   end
   // hang guard, well beyond the length of the sequence
   initial
   begin
      #(20000 * 100);
      n_errors++;
      results();
   end
endmodule
